// ### design/hub_ctrl_pkg.sv
// constants, field layouts and carrier types of the shared control bank
// assumes: one 100 MHz clock domain; the bank is reached over the two-wire bus
//
// Summary of operation
// [RULE_01] address field reads back address in use
// [RULE_02] select low: field read-only, shows strap
// [RULE_03] select high: written address becomes live
// [RULE_04] address select resets to zero
// [RULE_05] reload trigger restarts rom load, self-clears
// [RULE_06] host polls init-done after reload
// [RULE_07] init-done status set when load finishes
// [RULE_08] full reset clears logic and registers
// [RULE_09] keep-config reset clears logic only
// [RULE_10] host prefers keep-config reset
// [RULE_11] local master enable resets off
// [RULE_12] policy low, unlocked: transmit high impedance
// [RULE_13] policy high, unlocked: transmit rests lp11
// [RULE_14] idle select high, enable low: high impedance
// [RULE_15] unlocked, idle select low: drive hs0
// [RULE_16] parity check enable defaults on
// [RULE_17] refclk override forces clock present
// [RULE_18] revision register read-only, two nibbles
// [RULE_19] self-clear bits read zero, zero writes ignored
package hub_ctrl_pkg;
   // ==========================================
   // register offsets
   localparam logic [7:0] OFS_ADDR   = 8'h00;
   localparam logic [7:0] OFS_RESET  = 8'h01;
   localparam logic [7:0] OFS_CFG    = 8'h02;
   localparam logic [7:0] OFS_REV    = 8'h03;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   // ==========================================
   // field positions
   localparam int ADDR_SEL_BIT     = 0;
   localparam int RELOAD_BIT       = 2;
   localparam int FULL_RST_BIT     = 1;
   localparam int KEEP_RST_BIT     = 0;
   localparam int MASTER_EN_BIT    = 5;
   localparam int OEN_MODE_BIT     = 4;
   localparam int OUT_EN_BIT       = 3;
   localparam int SLEEP_SEL_BIT    = 2;
   localparam int PARITY_EN_BIT    = 1;
   localparam int REFCLK_OVR_BIT   = 0;
   localparam int INIT_DONE_BIT    = 6;
   localparam int REFCLK_VALID_BIT = 4;
   // ==========================================
   // reset values and masks
   localparam logic [7:0] CFG_RESET = 8'h1e;
   localparam logic [7:0] CFG_MASK  = 8'h3f;
   localparam logic [2:0] SC_MASK   = 3'h7;
   // revision nibbles: arbitrary values
   localparam logic [3:0] SILICON_REV_DEFAULT = 4'h0;
   localparam logic [3:0] MASK_REV_DEFAULT    = 4'h0;
   // ==========================================
   // timing counts
   localparam int ROM_LOAD_CYCLES    = 64;
   localparam int RESET_PULSE_CYCLES = 4;
   // ==========================================
   // types
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
      ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
   } i2c_state_t;
   typedef enum logic [1:0] {TX_NORMAL, TX_HIZ, TX_HS0, TX_LP11} tx_state_t;
   typedef struct packed {
      i2c_state_t  state;
      logic [7:0]  shift;
      logic [3:0]  bitcnt;
      logic [7:0]  ptr;
      logic        rw;
      logic        nack;
      logic        drv;
   } i2c_ctx_t;
endpackage

// ### design/i2c_line_events.sv
// bus condition detector for the two-wire control port
// assumes: scl and sda arrive synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module i2c_line_events (
   input  wire logic sys_clk,
   input  wire logic rstn,
   input  wire logic scl,
   input  wire logic sda,
   output logic      scl_rise,
   output logic      scl_fall,
   output logic      start,
   output logic      stop,
   output logic      sda_s
);
   logic scl_q;
   logic scl_qq;
   logic sda_qq;

   // two sample stages; idle bus is high
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         scl_q  <= 1'b1;
         scl_qq <= 1'b1;
         sda_s  <= 1'b1;
         sda_qq <= 1'b1;
      end else begin
         scl_q  <= scl;
         scl_qq <= scl_q;
         sda_s  <= sda;
         sda_qq <= sda_s;
      end
   end

   // sda moving while scl high marks start or stop
   assign scl_rise = scl_q & ~scl_qq;
   assign scl_fall = ~scl_q & scl_qq;
   assign start    = scl_q & scl_qq & sda_qq & ~sda_s;
   assign stop     = scl_q & scl_qq & ~sda_qq & sda_s;
endmodule
`default_nettype wire

// ### design/busy_timer.sv
// one-shot timer: busy for LEN cycles after a start pulse
// assumes: start is a single-cycle pulse; a restart while busy reloads
`timescale 1ns/1ps
`default_nettype none
module busy_timer #(
   parameter int LEN = 4
) (
   input  wire logic sys_clk,
   input  wire logic rstn,
   input  wire logic start,
   output logic      busy
);
   logic [15:0] cnt_r;

   // load, count down, drop busy on zero
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= 16'h0000;
         busy  <= 1'b0;
      end else if (start) begin
         cnt_r <= 16'(LEN - 1);
         busy  <= 1'b1;
      end else if (busy) begin
         cnt_r <= cnt_r - 16'h0001;
         busy  <= (cnt_r != 16'h0000);
      end
   end
endmodule
`default_nettype wire

// ### design/global_control_registers.sv
// shared control bank: bus address, soft resets, top enables, revision
// assumes: host reaches it over the two-wire port; rom and rx locks outside
`timescale 1ns/1ps
`default_nettype none
module global_control_registers #(
   parameter int         ROM_LOAD    = hub_ctrl_pkg::ROM_LOAD_CYCLES,
   parameter int         RST_PULSE   = hub_ctrl_pkg::RESET_PULSE_CYCLES,
   parameter logic [3:0] SILICON_REV = hub_ctrl_pkg::SILICON_REV_DEFAULT,
   parameter logic [3:0] MASK_REV    = hub_ctrl_pkg::MASK_REV_DEFAULT
) (
   input  wire logic                    sys_clk,
   input  wire logic                    rstn,
   input  wire logic                    scl,
   input  wire logic                    sda_in,
   output logic                         sda_out,
   output logic                         sda_oe_n,
   input  wire logic [6:0]              strap_address,
   input  wire logic                    any_rx_locked,
   input  wire logic                    refclk_detected,
   output logic [6:0]                   own_bus_address,
   output logic                         local_master_en,
   output logic                         parity_check_en,
   output logic                         refclk_present,
   output var hub_ctrl_pkg::tx_state_t  tx_state,
   output logic                         logic_reset,
   output logic                         init_done,
   output logic                         rom_reload_active
);
   localparam int LOAD_BOUND = ROM_LOAD + 4;

   // ==========================================
   // declarations
   hub_ctrl_pkg::i2c_ctx_t ctx_r;
   hub_ctrl_pkg::i2c_ctx_t ctx_nxt;
   logic        ev_rise;
   logic        ev_fall;
   logic        ev_start;
   logic        ev_stop;
   logic        sda_s;
   logic        boot_r;
   logic [6:0]  strap_r;
   logic        sel_r;
   logic [6:0]  ovr_addr_r;
   logic [7:0]  cfg_r;
   logic [2:0]  sc_r;
   logic [2:0]  sc_nxt;
   logic        rom_busy;
   logic        rst_busy;
   logic        rom_start;
   logic        rst_start;
   logic        full_clear;
   logic        wr_fire;
   logic [7:0]  wr_addr;
   logic [7:0]  wr_data;
   logic        wr_addr_reg;
   logic        wr_reset_reg;
   logic        wr_cfg_reg;
   logic [6:0]  cur_addr;
   logic        bit8;
   logic        addr_match;
   logic [7:0]  rd_cur;
   logic [7:0]  rd_next;
   logic        hiz_w;
   logic        hs0_w;
   logic        lp11_w;
   hub_ctrl_pkg::tx_state_t tx_nxt;

   // ==========================================
   // line conditions and timers
   i2c_line_events u_events (
      .sys_clk  (sys_clk),
      .rstn     (rstn),
      .scl      (scl),
      .sda      (sda_in),
      .scl_rise (ev_rise),
      .scl_fall (ev_fall),
      .start    (ev_start),
      .stop     (ev_stop),
      .sda_s    (sda_s)
   );

   // rom load window; init-done stays low while it runs
   busy_timer #(.LEN(ROM_LOAD)) u_rom_timer (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .start   (rom_start),
      .busy    (rom_busy)
   );

   // width of the internal logic reset pulse
   busy_timer #(.LEN(RST_PULSE)) u_rst_timer (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .start   (rst_start),
      .busy    (rst_busy)
   );

   // ==========================================
   // register read decode
   function automatic logic [7:0] reg_read(input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         hub_ctrl_pkg::OFS_ADDR:   v = {cur_addr, sel_r};
         hub_ctrl_pkg::OFS_RESET:  v = {5'h00, sc_r};
         hub_ctrl_pkg::OFS_CFG:    v = cfg_r;
         // [RULE_18] fixed revision nibbles
         hub_ctrl_pkg::OFS_REV:    v = {SILICON_REV, MASK_REV};
         // [RULE_07] status shows load done
         hub_ctrl_pkg::OFS_STATUS: begin
            v[hub_ctrl_pkg::INIT_DONE_BIT]    = init_done;
            v[hub_ctrl_pkg::REFCLK_VALID_BIT] = refclk_present;
         end
         default:                  v = 8'h00;
      endcase
      return v;
   endfunction

   assign rd_cur  = reg_read(ctx_r.ptr);
   assign rd_next = reg_read(ctx_r.ptr + 8'h01);

   // ==========================================
   // address selection
   // [RULE_01] live address readback
   assign cur_addr   = sel_r ? ovr_addr_r : strap_r;
   assign bit8       = (ctx_r.bitcnt == 4'h8);
   assign addr_match = (ctx_r.shift[7:1] == cur_addr);

   // strap caught one clock after release, never under reset
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         boot_r  <= 1'b1;
         strap_r <= 7'h00;
      end else begin
         boot_r <= 1'b0;
         if (boot_r) begin
            strap_r <= strap_address;
         end
      end
   end

   // ==========================================
   // two-wire slave: pointer byte, then data with auto-increment
   always_comb begin
      ctx_nxt = ctx_r;
      if (ev_stop) begin
         ctx_nxt.state = hub_ctrl_pkg::ST_IDLE;
         ctx_nxt.drv   = 1'b0;
      end else if (ev_start) begin
         ctx_nxt.state  = hub_ctrl_pkg::ST_ADDR;
         ctx_nxt.bitcnt = 4'h0;
         ctx_nxt.drv    = 1'b0;
      end else if (ev_rise) begin
         if (ctx_r.state inside {hub_ctrl_pkg::ST_ADDR, hub_ctrl_pkg::ST_PTR,
                                 hub_ctrl_pkg::ST_WDATA}) begin
            ctx_nxt.shift = {ctx_r.shift[6:0], sda_s};
         end
         if (ctx_r.state inside {hub_ctrl_pkg::ST_ADDR, hub_ctrl_pkg::ST_PTR,
                                 hub_ctrl_pkg::ST_WDATA, hub_ctrl_pkg::ST_RDATA}) begin
            ctx_nxt.bitcnt = ctx_r.bitcnt + 4'h1;
         end
         if (ctx_r.state == hub_ctrl_pkg::ST_RDATA_ACK) begin
            ctx_nxt.nack = sda_s;
         end
      end else if (ev_fall) begin
         unique case (ctx_r.state)
            hub_ctrl_pkg::ST_IDLE: begin
            end
            // [RULE_03] responds on live address
            hub_ctrl_pkg::ST_ADDR: if (bit8) begin
               if (addr_match) begin
                  ctx_nxt.state = hub_ctrl_pkg::ST_ADDR_ACK;
                  ctx_nxt.drv   = 1'b1;
                  ctx_nxt.rw    = ctx_r.shift[0];
               end else begin
                  ctx_nxt.state = hub_ctrl_pkg::ST_IDLE;
               end
            end
            hub_ctrl_pkg::ST_ADDR_ACK: begin
               ctx_nxt.bitcnt = 4'h0;
               if (ctx_r.rw) begin
                  ctx_nxt.shift = rd_cur;
                  ctx_nxt.drv   = ~rd_cur[7];
                  ctx_nxt.state = hub_ctrl_pkg::ST_RDATA;
               end else begin
                  ctx_nxt.drv   = 1'b0;
                  ctx_nxt.state = hub_ctrl_pkg::ST_PTR;
               end
            end
            hub_ctrl_pkg::ST_PTR: if (bit8) begin
               ctx_nxt.ptr   = ctx_r.shift;
               ctx_nxt.drv   = 1'b1;
               ctx_nxt.state = hub_ctrl_pkg::ST_PTR_ACK;
            end
            hub_ctrl_pkg::ST_PTR_ACK: begin
               ctx_nxt.drv    = 1'b0;
               ctx_nxt.bitcnt = 4'h0;
               ctx_nxt.state  = hub_ctrl_pkg::ST_WDATA;
            end
            hub_ctrl_pkg::ST_WDATA: if (bit8) begin
               ctx_nxt.drv   = 1'b1;
               ctx_nxt.state = hub_ctrl_pkg::ST_WDATA_ACK;
            end
            hub_ctrl_pkg::ST_WDATA_ACK: begin
               ctx_nxt.drv    = 1'b0;
               ctx_nxt.bitcnt = 4'h0;
               ctx_nxt.ptr    = ctx_r.ptr + 8'h01;
               ctx_nxt.state  = hub_ctrl_pkg::ST_WDATA;
            end
            hub_ctrl_pkg::ST_RDATA: begin
               if (bit8) begin
                  ctx_nxt.drv   = 1'b0;
                  ctx_nxt.state = hub_ctrl_pkg::ST_RDATA_ACK;
               end else begin
                  ctx_nxt.shift = {ctx_r.shift[6:0], 1'b0};
                  ctx_nxt.drv   = ~ctx_r.shift[6];
               end
            end
            // master nack ends the read burst
            hub_ctrl_pkg::ST_RDATA_ACK: begin
               if (ctx_r.nack) begin
                  ctx_nxt.state = hub_ctrl_pkg::ST_IDLE;
               end else begin
                  ctx_nxt.ptr    = ctx_r.ptr + 8'h01;
                  ctx_nxt.shift  = rd_next;
                  ctx_nxt.drv    = ~rd_next[7];
                  ctx_nxt.bitcnt = 4'h0;
                  ctx_nxt.state  = hub_ctrl_pkg::ST_RDATA;
               end
            end
         endcase
      end
   end

   // slave state; open-drain pin only ever pulls low
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ctx_r    <= '0;
         sda_out  <= 1'b0;
         sda_oe_n <= 1'b1;
      end else begin
         ctx_r    <= ctx_nxt;
         sda_out  <= 1'b0;
         sda_oe_n <= ~ctx_nxt.drv;
      end
   end

   // ==========================================
   // write decode: a data byte lands at its last falling edge
   assign wr_fire      = ev_fall & (ctx_r.state == hub_ctrl_pkg::ST_WDATA) & bit8;
   assign wr_addr      = ctx_r.ptr;
   assign wr_data      = ctx_r.shift;
   assign wr_addr_reg  = wr_fire & (wr_addr == hub_ctrl_pkg::OFS_ADDR);
   assign wr_reset_reg = wr_fire & (wr_addr == hub_ctrl_pkg::OFS_RESET);
   assign wr_cfg_reg   = wr_fire & (wr_addr == hub_ctrl_pkg::OFS_CFG);

   // [RULE_19] pending bits live one cycle
   assign sc_nxt     = wr_reset_reg ? (wr_data[2:0] & hub_ctrl_pkg::SC_MASK) : 3'h0;
   // [RULE_05] reload launch, also at power-on
   assign rom_start  = boot_r | sc_r[hub_ctrl_pkg::RELOAD_BIT];
   // [RULE_09] logic reset without clearing bank
   assign rst_start  = sc_r[hub_ctrl_pkg::FULL_RST_BIT] | sc_r[hub_ctrl_pkg::KEEP_RST_BIT];
   // [RULE_08] full reset also clears bank
   assign full_clear = sc_r[hub_ctrl_pkg::FULL_RST_BIT];

   // ==========================================
   // bank storage
   // [RULE_02] strap shown while select low
   // [RULE_04] select cleared on reset
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sel_r      <= 1'b0;
         ovr_addr_r <= 7'h00;
         cfg_r      <= hub_ctrl_pkg::CFG_RESET;
         sc_r       <= 3'h0;
      end else begin
         sc_r <= sc_nxt;
         if (full_clear) begin
            sel_r <= 1'b0;
            cfg_r <= hub_ctrl_pkg::CFG_RESET;
         end else begin
            if (wr_addr_reg) begin
               sel_r <= wr_data[hub_ctrl_pkg::ADDR_SEL_BIT];
            end
            // [RULE_03] field writable only with select
            if (wr_addr_reg && wr_data[hub_ctrl_pkg::ADDR_SEL_BIT]) begin
               ovr_addr_r <= wr_data[7:1];
            end
            if (wr_cfg_reg) begin
               cfg_r <= wr_data & hub_ctrl_pkg::CFG_MASK;
            end
         end
      end
   end

   // ==========================================
   // transmit output policy: hi-z beats hs0 beats lp11
   // [RULE_12] unlocked, policy low
   // [RULE_14] sleep select without enable
   assign hiz_w  = (~any_rx_locked & ~cfg_r[hub_ctrl_pkg::OEN_MODE_BIT]) |
                   (cfg_r[hub_ctrl_pkg::SLEEP_SEL_BIT] & ~cfg_r[hub_ctrl_pkg::OUT_EN_BIT]);
   // [RULE_15] unlocked sleep state hs0
   assign hs0_w  = ~any_rx_locked & ~cfg_r[hub_ctrl_pkg::SLEEP_SEL_BIT];
   // [RULE_13] unlocked, port control keeps lp11
   assign lp11_w = ~any_rx_locked & cfg_r[hub_ctrl_pkg::OEN_MODE_BIT];
   assign tx_nxt = hiz_w  ? hub_ctrl_pkg::TX_HIZ :
                   hs0_w  ? hub_ctrl_pkg::TX_HS0 :
                   lp11_w ? hub_ctrl_pkg::TX_LP11 : hub_ctrl_pkg::TX_NORMAL;

   // registered outputs
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         own_bus_address   <= 7'h00;
         local_master_en   <= 1'b0;
         parity_check_en   <= 1'b1;
         refclk_present    <= 1'b0;
         tx_state          <= hub_ctrl_pkg::TX_NORMAL;
         logic_reset       <= 1'b0;
         init_done         <= 1'b0;
         rom_reload_active <= 1'b0;
      end else begin
         own_bus_address   <= cur_addr;
         // [RULE_11] master follows enable bit
         local_master_en   <= cfg_r[hub_ctrl_pkg::MASTER_EN_BIT];
         // [RULE_16] parity checker enable
         parity_check_en   <= cfg_r[hub_ctrl_pkg::PARITY_EN_BIT];
         // [RULE_17] override or detector
         refclk_present    <= cfg_r[hub_ctrl_pkg::REFCLK_OVR_BIT] | refclk_detected;
         tx_state          <= tx_nxt;
         logic_reset       <= rst_start | rst_busy;
         // [RULE_07] done once load window closes
         init_done         <= ~(rom_start | rom_busy);
         rom_reload_active <= rom_start | rom_busy;
      end
   end

   // ==========================================
   // assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   sequence reload_req;
      wr_reset_reg && wr_data[hub_ctrl_pkg::RELOAD_BIT];
   endsequence
   sequence load_cycle;
      ##2 !init_done ##[1:LOAD_BOUND] init_done;
   endsequence
   sequence full_req;
      wr_reset_reg && wr_data[hub_ctrl_pkg::FULL_RST_BIT];
   endsequence

   strap_addr_a: assert property ( // [RULE_02]
      !sel_r && !boot_r |=> own_bus_address == $past(strap_r))
      else $error("address not from strap while select low");
   ovr_write_a: assert property ( // [RULE_03]
      wr_addr_reg && wr_data[0] && !full_clear |=> ##1 own_bus_address == $past(wr_data[7:1], 2))
      else $error("override address not taken");
   sel_reset_a: assert property ( // [RULE_04]
      boot_r |-> !sel_r && own_bus_address == 7'h00)
      else $error("address select not cleared by reset");
   reload_done_a: assert property ( // [RULE_05]
      reload_req |-> load_cycle)
      else $error("reload did not run and complete");
   init_flag_a: assert property ( // [RULE_07]
      rom_busy |=> !init_done)
      else $error("init done set during rom load");
   sc_clear_a: assert property ( // [RULE_19]
      (sc_r != 3'h0) && !wr_reset_reg |=> sc_r == 3'h0)
      else $error("self-clearing bit stuck");
   full_reset_a: assert property ( // [RULE_08]
      full_req |-> ##2 (logic_reset && cfg_r == hub_ctrl_pkg::CFG_RESET && !sel_r))
      else $error("full reset missed logic or registers");
   keep_reset_a: assert property ( // [RULE_09]
      wr_reset_reg && wr_data[0] && !wr_data[1] |-> ##2 (logic_reset && cfg_r == $past(cfg_r, 2)))
      else $error("keep-config reset disturbed registers");
   tx_hiz_a: assert property ( // [RULE_14]
      hiz_w |=> tx_state == hub_ctrl_pkg::TX_HIZ)
      else $error("transmit not high impedance");
   tx_hs0_a: assert property ( // [RULE_15]
      !any_rx_locked && !hiz_w && !cfg_r[2] |=> tx_state == hub_ctrl_pkg::TX_HS0)
      else $error("transmit not in hs0");
   refclk_ovr_a: assert property ( // [RULE_17]
      cfg_r[hub_ctrl_pkg::REFCLK_OVR_BIT] [*2] |-> refclk_present)
      else $error("refclk override ignored");
endmodule
`default_nettype wire

// ### verif/host_bus_model.sv
// two-wire bus host that reaches the shared control bank
// assumes: bench resolves the open-drain sda line and feeds it back
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
   input  wire logic sys_clk,
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_drv
);
   // ==========================================
   // idle: both lines released, pulled high
   initial begin
      scl     = 1'b1;
      sda_drv = 1'b1;
   end
   // five clocks a quarter keeps each scl phase above four clocks
   task automatic qtr();
      repeat (5) @(posedge sys_clk);
   endtask
   // sda moves only mid-low, sampled mid-high
   task automatic bit_io(input logic b, output logic got);
      scl <= 1'b0;
      qtr();
      sda_drv <= b;
      qtr();
      scl <= 1'b1;
      qtr();
      got = sda_line;
      qtr();
   endtask
   // also serves as repeated start
   task automatic start_c();
      scl <= 1'b0;
      qtr();
      sda_drv <= 1'b1;
      qtr();
      scl <= 1'b1;
      qtr();
      sda_drv <= 1'b0;
      qtr();
   endtask
   task automatic stop_c();
      scl <= 1'b0;
      qtr();
      sda_drv <= 1'b0;
      qtr();
      scl <= 1'b1;
      qtr();
      sda_drv <= 1'b1;
      qtr();
   endtask
   // ==========================================
   // byte plus ninth bit; msb first
   task automatic byte_io(input logic [7:0] tx, input logic a_in,
                          output logic [7:0] rx, output logic a_seen);
      logic g;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], g);
         rx[i] = g;
      end
      bit_io(a_in, a_seen);
   endtask
   // first byte after address is the pointer
   task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                            input logic [7:0] data, output logic ok);
      logic [7:0] r;
      logic       a0, a1, a2;
      start_c();
      byte_io({dev, 1'b0}, 1'b1, r, a0);
      byte_io(ptr, 1'b1, r, a1);
      byte_io(data, 1'b1, r, a2);
      stop_c();
      ok = !(a0 | a1 | a2);
   endtask
   // single byte read ends with nack then stop
   task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr,
                           output logic [7:0] data, output logic ok);
      logic [7:0] r;
      logic       a0, a1, a2, a3;
      start_c();
      byte_io({dev, 1'b0}, 1'b1, r, a0);
      byte_io(ptr, 1'b1, r, a1);
      start_c();
      byte_io({dev, 1'b1}, 1'b1, r, a2);
      byte_io(8'hff, 1'b1, data, a3);
      stop_c();
      ok = !(a0 | a1 | a2);
   endtask
endmodule
`default_nettype wire

// ### verif/global_control_registers_tb.sv
// self-checking bench for the shared control bank
// assumes: host_bus_model is the only other party on the bus
`timescale 1ns/1ps
`default_nettype none
module global_control_registers_tb;
   localparam logic [6:0] STRAP = 7'h3a;
   localparam logic [6:0] NEWA  = 7'h2c;
   // revision nibbles: arbitrary values
   localparam logic [3:0] SREV  = 4'h5;
   localparam logic [3:0] MREV  = 4'h9;
   // policy table: cfg value and expected tx state code
   localparam logic [7:0] PCFG [5] = '{8'h0e, 8'h16, 8'h1a, 8'h1e, 8'h1e};
   localparam logic [1:0] PTX  [5] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h0};
   logic                    sys_clk, rstn, scl, host_sda, lck, rfd, sda_out, sda_oe_n;
   logic                    mst_en, par_en, rf_pres, lrst, idone, rl_act, lr_q;
   logic [6:0]              strap, own_addr;
   wire logic               sda_in;
   hub_ctrl_pkg::tx_state_t tx_state;
   int                      n_mismatch, checks_done, n_pulse, n_hi;
   logic [7:0]              d;
   logic                    ok;
   // open-drain line with pull-up
   assign sda_in = (sda_oe_n | sda_out) & host_sda;
   // ==========================================
   // clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // counts logic reset pulses and their high cycles
   always @(posedge sys_clk) begin
      lr_q <= lrst;
      if (lrst === 1'b1 && lr_q !== 1'b1) n_pulse++;
      if (lrst === 1'b1) n_hi++;
   end
   host_bus_model host_u (.sys_clk(sys_clk), .sda_line(sda_in), .scl(scl), .sda_drv(host_sda));
   global_control_registers #(.ROM_LOAD(64), .RST_PULSE(2), .SILICON_REV(SREV),
      .MASK_REV(MREV)) dut_u (.sys_clk(sys_clk), .rstn(rstn), .scl(scl), .sda_in(sda_in),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .strap_address(strap), .any_rx_locked(lck),
      .refclk_detected(rfd), .own_bus_address(own_addr), .local_master_en(mst_en),
      .parity_check_en(par_en), .refclk_present(rf_pres), .tx_state(tx_state),
      .logic_reset(lrst), .init_done(idone), .rom_reload_active(rl_act));
   // ==========================================
   // checking and bus helpers
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rd(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] exp);
      host_u.read_reg(dev, ptr, d, ok);
      chk($sformatf("reg %h", ptr), exp, (ok === 1'b1) ? d : 8'hxx);
   endtask
   task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] dat);
      host_u.write_reg(dev, ptr, dat, ok);
      chk("write ack", 8'h01, {7'h00, ok});
   endtask
   // bounded poll of the status register; ends the run if init-done never shows
   task automatic poll_init(input logic [7:0] exp);
      for (int k = 0; k < 4; k++) begin
         host_u.read_reg(STRAP, 8'h04, d, ok);
         if (d[6] === 1'b1) break;
      end
      chk("status", exp, d);
      if (d[6] !== 1'b1) wrap_up();
   endtask
   // ==========================================
   // main sequence
   initial begin
      rstn = 1'b0;
      strap = STRAP;
      lck = 1'b0;
      rfd = 1'b0;
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      poll_init(8'h40);
      rd(STRAP, 8'h00, {STRAP, 1'b0});
      rd(STRAP, 8'h02, 8'h1e);
      rd(STRAP, 8'h03, {SREV, MREV});
      rd(STRAP, 8'h10, 8'h00);
      chk("master en", 8'h00, {7'h00, mst_en});
      chk("parity en", 8'h01, {7'h00, par_en});
      wr(STRAP, 8'h03, 8'hff);
      rd(STRAP, 8'h03, {SREV, MREV});
      wr(STRAP, 8'h00, {NEWA, 1'b0});
      rd(STRAP, 8'h00, {STRAP, 1'b0});
      wr(STRAP, 8'h02, 8'h3f);
      chk("master en", 8'h01, {7'h00, mst_en});
      chk("refclk", 8'h01, {7'h00, rf_pres});
      wr(STRAP, 8'h02, 8'h3c);
      chk("parity en", 8'h00, {7'h00, par_en});
      chk("refclk", 8'h00, {7'h00, rf_pres});
      rfd <= 1'b1;
      repeat (4) @(posedge sys_clk);
      chk("refclk", 8'h01, {7'h00, rf_pres});
      // unlocked cases first, last entry with lock
      for (int i = 0; i < 5; i++) begin
         lck <= (i == 4);
         wr(STRAP, 8'h02, PCFG[i]);
         repeat (4) @(posedge sys_clk);
         chk("tx state", {6'h00, PTX[i]}, {6'h00, tx_state});
      end
      wr(STRAP, 8'h00, {NEWA, 1'b1});
      repeat (4) @(posedge sys_clk);
      chk("bus addr", {1'b0, NEWA}, {1'b0, own_addr});
      rd(NEWA, 8'h00, {NEWA, 1'b1});
      host_u.read_reg(STRAP, 8'h00, d, ok);
      chk("old addr ack", 8'h00, {7'h00, ok});
      wr(NEWA, 8'h02, 8'h21);
      wr(NEWA, 8'h01, 8'h01);
      chk("pulses", 8'h01, 8'(n_pulse));
      chk("pulse len", 8'h03, 8'(n_hi));
      rd(NEWA, 8'h02, 8'h21);
      rd(NEWA, 8'h01, 8'h00);
      wr(NEWA, 8'h01, 8'h00);
      chk("pulses", 8'h01, 8'(n_pulse));
      wr(NEWA, 8'h01, 8'h02);
      chk("pulses", 8'h02, 8'(n_pulse));
      rd(STRAP, 8'h00, {STRAP, 1'b0});
      rd(STRAP, 8'h02, 8'h1e);
      chk("master en", 8'h00, {7'h00, mst_en});
      wr(STRAP, 8'h01, 8'h04);
      chk("reload busy", 8'h01, {7'h00, rl_act});
      chk("init done", 8'h00, {7'h00, idone});
      poll_init(8'h50);
      rd(STRAP, 8'h01, 8'h00);
      wrap_up();
   end
endmodule
`default_nettype wire
